/* design/pcd_regs.vh */
`ifndef PCD_REGS_VH
`define PCD_REGS_VH

// ------------------------------------------------------------
// register bus word indices
// ------------------------------------------------------------
`define PCD_REG_CTRL 4'h0
`define PCD_REG_TSEL 4'h1
`define PCD_REG_TSELX 4'h2
`define PCD_REG_RXMAP 4'h3
`define PCD_REG_TXMAP 4'h4
`define PCD_REG_STATUS 4'h5
`define PCD_REG_REQCNT 4'h6
`define PCD_REG_ERRCNT 4'h7
`define PCD_REG_PWIDTH 4'h8
`define PCD_REG_PINDEX 4'h9

// ------------------------------------------------------------
// control bits and reset values
// ------------------------------------------------------------
`define PCD_CTRL_MASTER 0
`define PCD_CTRL_AUTH 1
`define PCD_CTRL_RST 2'h3
`define PCD_TSEL_RST 16'h0001
`define PCD_TSELX_RST 16'h0001
`define PCD_FREE_SEL 16'h03E7
`define PCD_MAP_RST 8'hE4
`define PCD_PWIDTH_RST 16'h0000
`define PCD_PINDEX_RST 16'hFF00

// ------------------------------------------------------------
// parameter channel field positions
// ------------------------------------------------------------
`define PCD_ID_HI 15
`define PCD_ID_LO 12
`define PCD_RSVD_BIT 11
`define PCD_NUMBER_HI 10
`define PCD_NUMBER_LO 0
`define PCD_ELEM_HI 15
`define PCD_ELEM_LO 8
`define PCD_PAGE_HI 7
`define PCD_PAGE_LO 0

// ------------------------------------------------------------
// request identifiers
// ------------------------------------------------------------
`define PCD_RQ_NONE 4'h0
`define PCD_RQ_READ 4'h1
`define PCD_RQ_WR_W 4'h2
`define PCD_RQ_WR_D 4'h3
`define PCD_RQ_DESC 4'h4
`define PCD_RQ_READ_F 4'h6
`define PCD_RQ_WR_FW 4'h7
`define PCD_RQ_WR_FD 4'h8
`define PCD_RQ_COUNT 4'h9

// ------------------------------------------------------------
// response identifiers
// ------------------------------------------------------------
`define PCD_RS_NONE 4'h0
`define PCD_RS_VAL_W 4'h1
`define PCD_RS_VAL_D 4'h2
`define PCD_RS_DESC 4'h3
`define PCD_RS_FLD_W 4'h4
`define PCD_RS_FLD_D 4'h5
`define PCD_RS_COUNT 4'h6
`define PCD_RS_ERROR 4'h7
`define PCD_RS_NOAUTH 4'h8

// ------------------------------------------------------------
// error numbers
// ------------------------------------------------------------
`define PCD_ERR_NUMBER 8'h00
`define PCD_ERR_SUBIDX 8'h03
`define PCD_ERR_NOARRAY 8'h04
`define PCD_ERR_TYPE 8'h05
`define PCD_ERR_NOTSUP 8'h6A

`endif

/* design/pcd_param_mem.v */
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// parameter value store, registered read
// ------------------------------------------------------------
module pcd_param_mem #(
  parameter AW = 6,
  parameter DW = 32
) (
  input wire clock,
  input wire wr_en,
  input wire [AW-1:0] addr,
  input wire [DW-1:0] wdata,
  output reg [DW-1:0] rdata_q
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // registered read, old data on a same-address write
  always @(posedge clock) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
    rdata_q <= mem[addr];
  end

endmodule // pcd_param_mem

`default_nettype wire

/* design/pcd_word_sel.v */
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// one cyclic word slot, fixed or freely mapped
// ------------------------------------------------------------
module pcd_word_sel #(
  parameter SW = 2,
  parameter LANE = 0
) (
  input wire clock,
  input wire rst_n,
  input wire free_map,
  input wire [SW-1:0] sel,
  input wire [(16<<SW)-1:0] words,
  output reg [15:0] out_q
);

  wire [15:0] out_d;

  // pick mapped source or own lane
  assign out_d = free_map ? words[{sel, 4'h0} +: 16] : words[LANE*16 +: 16];

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 16'h0000;
    end else begin
      out_q <= out_d;
    end
  end

endmodule // pcd_word_sel

`default_nettype wire

/* design/pcd_decoder.v */
// Notes on behaviour
// - request and response are four 16-bit words
// - words 1-2 address, words 3-4 contents
// - top nibble of word 1 is identifier
// - bit 11 reserved, always returned zero
// - contents are 16-bit or 32-bit per parameter
// - id 2 stores word, answers 1 or 7/8
// - id 3 stores double, answers 2 or 7/8
// - reads answer 1/2 for id 1, 4/5 for id 6
// - id 7 writes element word, answers 4
// - id 8 writes element double, answers 5
// - id 4 returns descriptive element, answers 3
// - id 9 returns element count, answers 6
// - failure answers 7, error in word 3
// - writes missing control or authority answer 8
// - ids 1=6, 2=7, 3=8 handled alike
// - element taken from word 2
// - both selects 999 enable free mapping
// - parameter number in word 1 bits 10:0
// - range offset code in word 2 bits 7:0
// - element index in word 2 bits 15:8
// - 16-bit in word 4, 32-bit words 3-4
`timescale 1ns/1ns
`default_nettype none
`include "pcd_regs.vh"

module pcd_decoder #(
  parameter PW = 4,
  parameter EW = 2,
  parameter SW = 2
) (
  input wire clock,
  input wire rst_n,
  input wire req_valid,
  input wire [15:0] req_w1,
  input wire [15:0] req_w2,
  input wire [15:0] req_w3,
  input wire [15:0] req_w4,
  output reg rsp_valid,
  output reg [15:0] rsp_w1,
  output reg [15:0] rsp_w2,
  output reg [15:0] rsp_w3,
  output reg [15:0] rsp_w4,
  input wire [(16<<SW)-1:0] rx_words,
  output wire [(16<<SW)-1:0] rx_mapped,
  input wire [(16<<SW)-1:0] tx_signals,
  output wire [(16<<SW)-1:0] tx_words,
  output reg free_map_q,
  input wire [3:0] bus_addr,
  input wire [15:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [15:0] bus_rdata
);

  localparam NPAR = 1 << PW;
  localparam AW = PW + EW;
  localparam MW = SW << SW;
  localparam [7:0] NELEM = 8'h01 << EW;

  // ----------------------------------------------------------
  // software registers
  // ----------------------------------------------------------
  reg [1:0] ctrl_q;
  reg [15:0] tsel_q;
  reg [15:0] tselx_q;
  reg [MW-1:0] rxmap_q;
  reg [MW-1:0] txmap_q;
  reg [NPAR-1:0] pwidth_q;
  reg [NPAR-1:0] pindex_q;
  reg [15:0] reqcnt_q;
  reg [15:0] errcnt_q;
  reg [3:0] last_id_q;
  reg [7:0] last_err_q;

  // register writes
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `PCD_CTRL_RST;
      tsel_q <= `PCD_TSEL_RST;
      tselx_q <= `PCD_TSELX_RST;
      rxmap_q <= `PCD_MAP_RST;
      txmap_q <= `PCD_MAP_RST;
      pwidth_q <= `PCD_PWIDTH_RST;
      pindex_q <= `PCD_PINDEX_RST;
    end else if (bus_wr) begin
      case (bus_addr)
        `PCD_REG_CTRL: ctrl_q <= bus_wdata[1:0];
        `PCD_REG_TSEL: tsel_q <= bus_wdata;
        `PCD_REG_TSELX: tselx_q <= bus_wdata;
        `PCD_REG_RXMAP: rxmap_q <= bus_wdata[MW-1:0];
        `PCD_REG_TXMAP: txmap_q <= bus_wdata[MW-1:0];
        `PCD_REG_PWIDTH: pwidth_q <= bus_wdata[NPAR-1:0];
        `PCD_REG_PINDEX: pindex_q <= bus_wdata[NPAR-1:0];
        default: ;
      endcase
    end
  end

  // register reads, data one cycle later, unmapped reads zero
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 16'h0000;
    end else if (bus_rd) begin
      case (bus_addr)
        `PCD_REG_CTRL: bus_rdata <= {14'h0000, ctrl_q};
        `PCD_REG_TSEL: bus_rdata <= tsel_q;
        `PCD_REG_TSELX: bus_rdata <= tselx_q;
        `PCD_REG_RXMAP: bus_rdata <= {{(16-MW){1'b0}}, rxmap_q};
        `PCD_REG_TXMAP: bus_rdata <= {{(16-MW){1'b0}}, txmap_q};
        `PCD_REG_STATUS: bus_rdata <= {last_err_q, 3'h0, free_map_q,
                                       last_id_q};
        `PCD_REG_REQCNT: bus_rdata <= reqcnt_q;
        `PCD_REG_ERRCNT: bus_rdata <= errcnt_q;
        `PCD_REG_PWIDTH: bus_rdata <= {{(16-NPAR){1'b0}}, pwidth_q};
        `PCD_REG_PINDEX: bus_rdata <= {{(16-NPAR){1'b0}}, pindex_q};
        default: bus_rdata <= 16'h0000;
      endcase
    end else begin
      bus_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------------------------
  // cyclic word mapping
  // ----------------------------------------------------------
  // free mapping only when both selections hold 999
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      free_map_q <= 1'b0;
    end else begin
      free_map_q <= (tsel_q == `PCD_FREE_SEL) &&
                    (tselx_q == `PCD_FREE_SEL);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < (1 << SW); gi = gi + 1) begin : g_map
      pcd_word_sel #(.SW(SW), .LANE(gi)) u_rx (
        .clock(clock),
        .rst_n(rst_n),
        .free_map(free_map_q),
        .sel(rxmap_q[gi*SW +: SW]),
        .words(rx_words),
        .out_q(rx_mapped[gi*16 +: 16])
      );
      pcd_word_sel #(.SW(SW), .LANE(gi)) u_tx (
        .clock(clock),
        .rst_n(rst_n),
        .free_map(free_map_q),
        .sel(txmap_q[gi*SW +: SW]),
        .words(tx_signals),
        .out_q(tx_words[gi*16 +: 16])
      );
    end
  endgenerate

  // ----------------------------------------------------------
  // stage 1: captured request words
  // ----------------------------------------------------------
  reg s1_valid_q;
  reg [15:0] q1_q;
  reg [15:0] q2_q;
  reg [15:0] q3_q;
  reg [15:0] q4_q;

  // four words taken together in one cycle
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_valid_q <= 1'b0;
      q1_q <= 16'h0000;
      q2_q <= 16'h0000;
      q3_q <= 16'h0000;
      q4_q <= 16'h0000;
    end else begin
      s1_valid_q <= req_valid;
      if (req_valid) begin
        q1_q <= req_w1;
        q2_q <= req_w2;
        q3_q <= req_w3;
        q4_q <= req_w4;
      end
    end
  end

  // field extraction
  wire [3:0] rq_id = q1_q[`PCD_ID_HI:`PCD_ID_LO];
  wire [10:0] param_number_field =
    q1_q[`PCD_NUMBER_HI:`PCD_NUMBER_LO];
  wire [7:0] page = q2_q[`PCD_PAGE_HI:`PCD_PAGE_LO];
  wire [7:0] elem = q2_q[`PCD_ELEM_HI:`PCD_ELEM_LO];
  wire [PW-1:0] pidx = param_number_field[PW-1:0];
  wire exists = (page == 8'h00) && (param_number_field[10:PW] == 0);
  wire is_dw = pwidth_q[pidx];
  wire is_ix = pindex_q[pidx];
  wire elem_ok = is_ix ? (elem < NELEM) : (elem == 8'h00);
  wire authorised = ctrl_q[`PCD_CTRL_MASTER] & ctrl_q[`PCD_CTRL_AUTH];

  // identifier classes, 1=6, 2=7, 3=8
  wire is_rd = (rq_id == `PCD_RQ_READ) || (rq_id == `PCD_RQ_READ_F);
  wire is_ww = (rq_id == `PCD_RQ_WR_W) || (rq_id == `PCD_RQ_WR_FW);
  wire is_wd = (rq_id == `PCD_RQ_WR_D) || (rq_id == `PCD_RQ_WR_FD);
  wire is_fld = (rq_id == `PCD_RQ_READ_F) || (rq_id == `PCD_RQ_WR_FW) ||
                (rq_id == `PCD_RQ_WR_FD);

  // ----------------------------------------------------------
  // decode and check
  // ----------------------------------------------------------
  reg [3:0] rs_id;
  reg [7:0] err_no;
  reg use_mem;
  reg mem_we;
  reg [31:0] cval;

  always @* begin
    rs_id = `PCD_RS_NONE;
    err_no = 8'h00;
    use_mem = 1'b0;
    mem_we = 1'b0;
    cval = 32'h0000_0000;
    if (rq_id == `PCD_RQ_NONE) begin
      rs_id = `PCD_RS_NONE;
    end else if (!(is_rd || is_ww || is_wd || rq_id == `PCD_RQ_DESC ||
                   rq_id == `PCD_RQ_COUNT)) begin
      rs_id = `PCD_RS_ERROR;
      err_no = `PCD_ERR_NOTSUP;
    end else if ((is_ww || is_wd) && !authorised) begin
      rs_id = `PCD_RS_NOAUTH;
    end else if (!exists) begin
      rs_id = `PCD_RS_ERROR;
      err_no = `PCD_ERR_NUMBER;
    end else if (rq_id == `PCD_RQ_COUNT) begin
      if (is_ix) begin
        rs_id = `PCD_RS_COUNT;
        cval = {24'h000000, NELEM};
      end else begin
        rs_id = `PCD_RS_ERROR;
        err_no = `PCD_ERR_NOARRAY;
      end
    end else if (rq_id == `PCD_RQ_DESC) begin
      // element 0 width code, element 1 element count
      if (elem == 8'h00) begin
        rs_id = `PCD_RS_DESC;
        cval = {31'h0000_0000, is_dw};
      end else if (elem == 8'h01) begin
        rs_id = `PCD_RS_DESC;
        cval = {24'h000000, is_ix ? NELEM : 8'h01};
      end else begin
        rs_id = `PCD_RS_ERROR;
        err_no = `PCD_ERR_SUBIDX;
      end
    end else if (!elem_ok) begin
      rs_id = `PCD_RS_ERROR;
      err_no = is_ix ? `PCD_ERR_SUBIDX : `PCD_ERR_NOARRAY;
    end else if (is_rd) begin
      use_mem = 1'b1;
      if (is_fld) begin
        rs_id = is_dw ? `PCD_RS_FLD_D : `PCD_RS_FLD_W;
      end else begin
        rs_id = is_dw ? `PCD_RS_VAL_D : `PCD_RS_VAL_W;
      end
    end else if (is_ww) begin
      if (is_dw) begin
        rs_id = `PCD_RS_ERROR;
        err_no = `PCD_ERR_TYPE;
      end else begin
        mem_we = 1'b1;
        cval = {16'h0000, q4_q};
        rs_id = is_fld ? `PCD_RS_FLD_W : `PCD_RS_VAL_W;
      end
    end else begin
      if (!is_dw) begin
        rs_id = `PCD_RS_ERROR;
        err_no = `PCD_ERR_TYPE;
      end else begin
        mem_we = 1'b1;
        cval = {q3_q, q4_q};
        rs_id = is_fld ? `PCD_RS_FLD_D : `PCD_RS_VAL_D;
      end
    end
  end

  // ----------------------------------------------------------
  // parameter store
  // ----------------------------------------------------------
  wire [31:0] mem_rdata;
  wire [AW-1:0] mem_addr = {pidx, elem[EW-1:0]};

  pcd_param_mem #(.AW(AW), .DW(32)) u_mem (
    .clock(clock),
    .wr_en(s1_valid_q & mem_we),
    .addr(mem_addr),
    .wdata(cval),
    .rdata_q(mem_rdata)
  );

  // ----------------------------------------------------------
  // stage 2: decoded result beside read data
  // ----------------------------------------------------------
  reg s2_valid_q;
  reg [3:0] s2_id_q;
  reg [7:0] s2_err_q;
  reg s2_mem_q;
  reg s2_dw_q;
  reg [31:0] s2_val_q;
  reg [10:0] s2_number_q;
  reg [15:0] s2_w2_q;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s2_valid_q <= 1'b0;
      s2_id_q <= 4'h0;
      s2_err_q <= 8'h00;
      s2_mem_q <= 1'b0;
      s2_dw_q <= 1'b0;
      s2_val_q <= 32'h0000_0000;
      s2_number_q <= 11'h000;
      s2_w2_q <= 16'h0000;
    end else begin
      s2_valid_q <= s1_valid_q;
      if (s1_valid_q) begin
        s2_id_q <= rs_id;
        s2_err_q <= err_no;
        s2_mem_q <= use_mem;
        s2_dw_q <= is_dw;
        s2_val_q <= cval;
        s2_number_q <= param_number_field;
        s2_w2_q <= q2_q;
      end
    end
  end

  // ----------------------------------------------------------
  // response words
  // ----------------------------------------------------------
  reg [15:0] w3_d;
  reg [15:0] w4_d;

  // contents placement by outcome and width
  always @* begin
    w3_d = 16'h0000;
    w4_d = 16'h0000;
    if (s2_id_q == `PCD_RS_ERROR) begin
      w3_d = {8'h00, s2_err_q};
    end else if (s2_mem_q) begin
      w3_d = s2_dw_q ? mem_rdata[31:16] : 16'h0000;
      w4_d = mem_rdata[15:0];
    end else begin
      w3_d = s2_val_q[31:16];
      w4_d = s2_val_q[15:0];
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_w1 <= 16'h0000;
      rsp_w2 <= 16'h0000;
      rsp_w3 <= 16'h0000;
      rsp_w4 <= 16'h0000;
    end else begin
      rsp_valid <= s2_valid_q;
      if (s2_valid_q) begin
        rsp_w1 <= {s2_id_q, 1'b0, s2_number_q};
        rsp_w2 <= s2_w2_q;
        rsp_w3 <= w3_d;
        rsp_w4 <= w4_d;
      end
    end
  end

  // status and counters
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reqcnt_q <= 16'h0000;
      errcnt_q <= 16'h0000;
      last_id_q <= 4'h0;
      last_err_q <= 8'h00;
    end else if (s2_valid_q) begin
      reqcnt_q <= reqcnt_q + 16'h0001;
      last_id_q <= s2_id_q;
      last_err_q <= s2_err_q;
      if (s2_id_q == `PCD_RS_ERROR || s2_id_q == `PCD_RS_NOAUTH) begin
        errcnt_q <= errcnt_q + 16'h0001;
      end
    end
  end

endmodule // pcd_decoder

`default_nettype wire

/* dv/pcd_decoder_sva.sv */
`timescale 1ns/1ns
`default_nettype none
// ----
// parameter channel port checks
// ----
module pcd_decoder_sva #(
  parameter PW = 4,
  parameter EW = 2,
  parameter SW = 2
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic [15:0] req_w1,
  input wire logic [15:0] req_w2,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_w1,
  input wire logic [15:0] rsp_w2,
  input wire logic [15:0] rsp_w3,
  input wire logic [15:0] rsp_w4,
  input wire logic [(16<<SW)-1:0] rx_words,
  input wire logic [(16<<SW)-1:0] rx_mapped,
  input wire logic free_map_q,
  input wire logic bus_wr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // request taken, answer sampled three edges on
  sequence s_req;
    req_valid;
  endsequence
  sequence s_rsp;
    ##3 rsp_valid;
  endsequence
  property p_lat;
    s_req |-> s_rsp;
  endproperty
  a_lat: assert property (p_lat)
    else $error("response not three cycles after request");
  property p_spur;
    rsp_valid |-> $past(req_valid, 3);
  endproperty
  a_spur: assert property (p_spur)
    else $error("response without request");
  property p_rsvd;
    rsp_valid |-> !rsp_w1[11];
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bit set in response");
  property p_echo;
    s_req |-> ##3 rsp_w1[10:0] == $past(req_w1[10:0], 3);
  endproperty
  a_echo: assert property (p_echo)
    else $error("parameter number not echoed");
  property p_idx;
    s_req |-> ##3 rsp_w2 == $past(req_w2, 3);
  endproperty
  a_idx: assert property (p_idx)
    else $error("index word not echoed");
  property p_none;
    req_valid && req_w1[15:12] == 4'h0 |-> ##3 rsp_w1[15:12] == 4'h0
      && rsp_w3 == 16'h0000 && rsp_w4 == 16'h0000;
  endproperty
  a_none: assert property (p_none)
    else $error("empty job not answered with zero");
  property p_err;
    rsp_valid && rsp_w1[15:12] == 4'h7 |-> rsp_w3[15:8] == 8'h00
      && rsp_w4 == 16'h0000;
  endproperty
  a_err: assert property (p_err)
    else $error("error answer malformed");
  property p_unsup;
    req_valid && (req_w1[15:12] == 4'h5 || req_w1[15:12] > 4'h9)
      |-> ##3 rsp_w1[15:12] == 4'h7 && rsp_w3 == 16'h006A;
  endproperty
  a_unsup: assert property (p_unsup)
    else $error("unknown job not refused");
  property p_auth;
    rsp_valid && rsp_w1[15:12] == 4'h8
      |-> $past(req_w1[15:12], 3) inside {4'h2, 4'h3, 4'h7, 4'h8};
  endproperty
  a_auth: assert property (p_auth)
    else $error("authority refusal on a non-write job");
  property p_word;
    rsp_valid && rsp_w1[15:12] inside {4'h1, 4'h4} |-> rsp_w3 == 16'h0000;
  endproperty
  a_word: assert property (p_word)
    else $error("single word value has upper word set");
  property p_free;
    $changed(free_map_q) |-> $past(bus_wr) || $past(bus_wr, 2);
  endproperty
  a_free: assert property (p_free)
    else $error("free mapping changed without a write");
  property p_rx;
    !free_map_q |=> rx_mapped == $past(rx_words);
  endproperty
  a_rx: assert property (p_rx)
    else $error("fixed mapping not a pass-through");
endmodule // pcd_decoder_sva

bind pcd_decoder pcd_decoder_sva #(.PW(PW), .EW(EW), .SW(SW)) sva_u (
  .clock, .rst_n, .req_valid, .req_w1, .req_w2, .rsp_valid, .rsp_w1,
  .rsp_w2, .rsp_w3, .rsp_w4, .rx_words, .rx_mapped, .free_map_q, .bus_wr);
`default_nettype wire

/* dv/pcd_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----
// bus controller issuing parameter jobs
// ----
module pcd_host_model (
  input wire logic clock,
  input wire logic go,
  input wire logic [3:0] id,
  input wire logic [10:0] number,
  input wire logic [15:0] index_word,
  input wire logic [31:0] val,
  output logic req_valid = 1'b0,
  output logic [15:0] req_w1 = 16'h0000,
  output logic [15:0] req_w2 = 16'h0000,
  output logic [15:0] req_w3 = 16'h0000,
  output logic [15:0] req_w4 = 16'h0000
);
  // one job per go pulse, lines scrambled while idle
  always_ff @(posedge clock) begin
    req_valid <= go;
    if (go) begin
      req_w1 <= {id, 1'b0, number};
      req_w2 <= index_word;
      req_w3 <= val[31:16];
      req_w4 <= val[15:0];
    end else begin
      req_w1 <= ~req_w1;
      req_w2 <= ~req_w2;
      req_w3 <= ~req_w3;
      req_w4 <= ~req_w4;
    end
  end
endmodule // pcd_host_model
`default_nettype wire

/* dv/parameter_channel_decoder_test.sv */
`timescale 1ns/1ns
`default_nettype none
module parameter_channel_decoder_test;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic [3:0] id = 4'h0;
  logic [10:0] number = 11'h000;
  logic [15:0] index_word = 16'h0000;
  logic [31:0] val = 32'h0000_0000;
  logic req_valid, rsp_valid, free_map_q;
  logic [15:0] req_w1, req_w2, req_w3, req_w4;
  logic [15:0] rsp_w1, rsp_w2, rsp_w3, rsp_w4, bus_rdata;
  logic [63:0] rx_words = 64'h4444_3333_2222_1111;
  logic [63:0] tx_signals = 64'hDDDD_CCCC_BBBB_AAAA;
  logic [63:0] rx_mapped, tx_words;
  logic [3:0] bus_addr = 4'h0;
  logic [15:0] bus_wdata = 16'h0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  int fail_count = 0;
  int checks = 0;
  int req_n = 0;
  int err_n = 0;

  // clock
  always #50 clock = ~clock;

  pcd_decoder #(.PW(4), .EW(2), .SW(2)) dut_u (.clock, .rst_n,
    .req_valid, .req_w1, .req_w2, .req_w3, .req_w4, .rsp_valid, .rsp_w1,
    .rsp_w2, .rsp_w3, .rsp_w4, .rx_words, .rx_mapped, .tx_signals,
    .tx_words, .free_map_q, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .bus_rdata);
  pcd_host_model host_u (.clock, .go, .id, .number, .index_word, .val,
    .req_valid, .req_w1, .req_w2, .req_w3, .req_w4);

  // ----
  // tasks
  // ----
  task automatic chk(input logic [64:0] got, input logic [64:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clock);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clock);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clock);
    bus_rd <= 1'b0;
    @(negedge clock);
    chk(bus_rdata, e);
  endtask
  // one job, wait for its answer, compare all four words
  task automatic rq(input logic [3:0] i, input logic [10:0] p,
      input logic [15:0] x, input logic [31:0] v,
      input logic [3:0] ei, input logic [31:0] ev);
    int n;
    n = 0;
    @(posedge clock);
    go <= 1'b1;
    id <= i;
    number <= p;
    index_word <= x;
    val <= v;
    @(posedge clock);
    go <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 8) begin
      @(negedge clock);
      n++;
    end
    chk({rsp_valid, rsp_w1, rsp_w2, rsp_w3, rsp_w4},
      {1'b1, ei, 1'b0, p, x, ev});
    req_n++;
    if (ei >= 4'h7) err_n++;
  endtask
  task automatic test_done;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (5000) @(posedge clock);
    fail_count++;
    test_done;
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    rd(4'h0, 16'h0003);
    rd(4'h1, 16'h0001);
    rd(4'h2, 16'h0001);
    rd(4'h3, 16'h00E4);
    rd(4'h4, 16'h00E4);
    rd(4'h8, 16'h0000);
    rd(4'h9, 16'hFF00);
    rd(4'hF, 16'h0000);
    chk(rx_mapped, rx_words);
    chk(tx_words, tx_signals);
    wr(4'h8, 16'h0402);
    wr(4'h6, 16'h5555);
    rd(4'h6, 16'h0000);
    rq(4'h0, 11'd3, 16'h0, 32'h0, 4'h0, 32'h0);
    rq(4'h2, 11'd3, 16'h0, 32'h1234, 4'h1, 32'h1234);
    rq(4'h1, 11'd3, 16'h0, 32'h0, 4'h1, 32'h1234);
    rq(4'h6, 11'd3, 16'h0, 32'h0, 4'h4, 32'h1234);
    rq(4'h1, 11'd3, 16'h0100, 32'h0, 4'h7, 32'h0004_0000);
    rq(4'h3, 11'd1, 16'h0, 32'hCAFE_0001, 4'h2, 32'hCAFE_0001);
    rq(4'h6, 11'd1, 16'h0, 32'h0, 4'h5, 32'hCAFE_0001);
    rq(4'h2, 11'd1, 16'h0, 32'h7, 4'h7, 32'h0005_0000);
    rq(4'h7, 11'd9, 16'h0200, 32'hAB, 4'h4, 32'hAB);
    rq(4'h6, 11'd9, 16'h0200, 32'h0, 4'h4, 32'hAB);
    rq(4'h6, 11'd9, 16'h0400, 32'h0, 4'h7, 32'h0003_0000);
    rq(4'h8, 11'd10, 16'h0300, 32'h89AB_CDEF, 4'h5, 32'h89AB_CDEF);
    rq(4'h1, 11'd10, 16'h0300, 32'h0, 4'h2, 32'h89AB_CDEF);
    rq(4'h4, 11'd10, 16'h0000, 32'h0, 4'h3, 32'h1);
    rq(4'h4, 11'd10, 16'h0100, 32'h0, 4'h3, 32'h4);
    rq(4'h9, 11'd9, 16'h0, 32'h0, 4'h6, 32'h4);
    rq(4'h9, 11'd3, 16'h0, 32'h0, 4'h7, 32'h0004_0000);
    rq(4'h1, 11'd3, 16'h0080, 32'h0, 4'h7, 32'h0);
    rq(4'h1, 11'd16, 16'h0, 32'h0, 4'h7, 32'h0);
    rq(4'h5, 11'd3, 16'h0, 32'h0, 4'h7, 32'h006A_0000);
    for (int c = 10; c < 16; c++)
      rq(c[3:0], 11'd3, 16'h0, 32'h0, 4'h7, 32'h006A_0000);
    rd(4'h5, 16'h6A07);
    wr(4'h0, 16'h0001);
    rq(4'h2, 11'd3, 16'h0, 32'h5, 4'h8, 32'h0);
    rq(4'h1, 11'd3, 16'h0, 32'h0, 4'h1, 32'h1234);
    wr(4'h0, 16'h0003);
    wr(4'h3, 16'h001B);
    wr(4'h4, 16'h001B);
    wr(4'h1, 16'h03E7);
    repeat (3) @(negedge clock);
    chk(free_map_q, 1'b0);
    wr(4'h2, 16'h03E7);
    repeat (3) @(negedge clock);
    chk(free_map_q, 1'b1);
    chk(rx_mapped, 64'h1111_2222_3333_4444);
    chk(tx_words, 64'hAAAA_BBBB_CCCC_DDDD);
    rd(4'h5, 16'h0011);
    rd(4'h6, req_n[15:0]);
    rd(4'h7, err_n[15:0]);
    test_done;
  end
endmodule // parameter_channel_decoder_test
`default_nettype wire
